//--- dmr_top.v
`timescale 1ns/100ps
`include "dmr_map.vh"
module dmr_top #(
  parameter [31:0] TIMEOUT_CYC = `DMR_TIMEOUT_CYC,
  parameter [31:0] MARGIN_CYC = `DMR_MARGIN_CYC,
  parameter [31:0] SPLIT_CYC = `DMR_SPLIT_CYC
) (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // serial bus pins, open drain
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  // system side
  input wire vsync_in,
  input wire sys_ready,
  input wire internal_clock_select,
  output wire control_ready,
  // applied settings
  output reg [4:0] drive_mode,
  output reg sixty_hz_standard,
  output reg [5:0] test_pattern_select,
  output reg [7:0] power_lower_gain,
  output reg [7:0] constant_level_gain,
  output reg constant_level_switch,
  output reg [8:0] power_limit_offset,
  // nonvolatile store write request
  output reg nvm_wr,
  output reg [15:0] nvm_addr,
  output reg [15:0] nvm_data
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_WR = 3'h2;
localparam [2:0] ST_ACK = 3'h3;
localparam [2:0] ST_RD = 3'h4;
localparam [2:0] ST_MACK = 3'h5;

wire scl_s;
wire sda_s;
wire vs_s;
wire ready_s;
wire vs_rise;
wire sixty;
reg scl_p_q;
reg sda_p_q;
reg [2:0] state_q;
reg [3:0] bit_q;
reg [7:0] sh_q;
reg drive_q;
reg rd_q;
reg lo_q;
reg mack_q;
reg [1:0] idx_q;
reg [15:0] ptr_q;
reg [7:0] hi_q;
reg [31:0] tmo_q;
reg wr_go_q;
reg [15:0] wr_addr_q;
reg [15:0] wr_data_q;
reg block_q;
reg [1:0] frames_q;
reg [31:0] marg_q;
reg [4:0] mode_q;
reg [5:0] pat_q [0:1];
reg [7:0] low_q [0:1];
reg [7:0] lvl_q [0:1];
reg sw_q [0:1];
reg [8:0] ofs_q [0:1];
reg [15:0] rd_word;
reg [7:0] rd_byte;

// bus lines idle high, so no false edge follows reset
dmr_sync2 #(
  .W(4),
  .INIT(4'hc)
) u_sync (
  .mclk(mclk),
  .rstn(rstn),
  .async_in({scl_in, sda_in, vsync_in, sys_ready}),
  .sync_out({scl_s, sda_s, vs_s, ready_s})
);

dmr_vsync_rate #(
  .SPLIT_CYC(SPLIT_CYC)
) u_rate (
  .mclk(mclk),
  .rstn(rstn),
  .vsync_s(vs_s),
  .vsync_rise(vs_rise),
  .sixty_hz(sixty)
);

wire scl_rise = scl_s & ~scl_p_q;
wire scl_fall = ~scl_s & scl_p_q;
wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
wire accept = ready_s & ~block_q;
wire load_rd = scl_fall & (((state_q == ST_ACK) & rd_q) | ((state_q == ST_MACK) & mack_q));

// register decode of the read pointer and the pending word write
wire [15:0] r_ofs = ptr_q & `DMR_OFS_MASK;
wire [15:0] r_set = ptr_q & `DMR_SET_MASK;
wire r_idx = ptr_q[`DMR_SET_BIT];
wire [15:0] w_ofs = wr_addr_q & `DMR_OFS_MASK;
wire [15:0] w_set = wr_addr_q & `DMR_SET_MASK;
wire w_idx = wr_addr_q[`DMR_SET_BIT];
wire [1:0] w_opt = wr_addr_q[`DMR_OPT_HI:`DMR_OPT_LO];
wire w_ram = wr_go_q & w_opt[1];
wire [4:0] w_code = wr_data_q[`DMR_MODE_CODE_HI:0];
wire code_ok = (w_code == `DMR_CODE_NORMAL) | (w_code == `DMR_CODE_STEREO) |
  (w_code == `DMR_CODE_CINEMA) | (w_code == `DMR_CODE_DYN);
wire mode_wr = w_ram & (w_ofs == (`DMR_ADDR_MODE & `DMR_OFS_MASK)) & code_ok;

assign sda_out = 1'b0;
assign sda_oe_n = ~drive_q;
assign control_ready = ready_s;

// read mux
always @*
begin
  rd_word = 16'h0000;
  if (r_ofs == (`DMR_ADDR_MODE & `DMR_OFS_MASK))
  begin
    rd_word[`DMR_MODE_FLAG_BIT] = sixty;
    rd_word[`DMR_MODE_CODE_HI:0] = mode_q;
  end
  else if (r_set == (`DMR_ADDR_PAT60 & `DMR_SET_MASK))
  begin
    rd_word[`DMR_PAT_HI:0] = pat_q[r_idx];
  end
  else if (r_set == (`DMR_ADDR_LOW60 & `DMR_SET_MASK))
  begin
    rd_word[`DMR_LOW_HI:0] = low_q[r_idx];
  end
  else if (r_set == (`DMR_ADDR_LVL60 & `DMR_SET_MASK))
  begin
    rd_word[`DMR_LVL_HI:`DMR_LVL_LO] = lvl_q[r_idx];
    rd_word[`DMR_LVL_SW_BIT] = sw_q[r_idx];
  end
  else if (r_set == (`DMR_ADDR_OFS60 & `DMR_SET_MASK))
  begin
    rd_word[`DMR_OFS_HI:0] = ofs_q[r_idx];
  end
  rd_byte = lo_q ? rd_word[7:0] : rd_word[15:8];
end

// serial bus slave
always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
  begin
    scl_p_q <= 1'b1;
    sda_p_q <= 1'b1;
    state_q <= ST_IDLE;
    bit_q <= 4'h0;
    sh_q <= 8'h00;
    drive_q <= 1'b0;
    rd_q <= 1'b0;
    lo_q <= 1'b0;
    mack_q <= 1'b0;
    idx_q <= 2'h0;
    ptr_q <= 16'h0000;
    hi_q <= 8'h00;
    tmo_q <= 32'h0000_0000;
    wr_go_q <= 1'b0;
    wr_addr_q <= 16'h0000;
    wr_data_q <= 16'h0000;
  end
  else
  begin
    scl_p_q <= scl_s;
    sda_p_q <= sda_s;
    wr_go_q <= 1'b0;
    if (start_c)
    begin
      state_q <= accept ? ST_ADDR : ST_IDLE;
      bit_q <= 4'h0;
      drive_q <= 1'b0;
      tmo_q <= 32'h0000_0000;
    end
    else if (stop_c)
    begin
      state_q <= ST_IDLE;
      drive_q <= 1'b0;
    end
    else if ((state_q != ST_IDLE) && (tmo_q >= TIMEOUT_CYC))
    begin
      state_q <= ST_IDLE;
      drive_q <= 1'b0;
    end
    else
    begin
      if (state_q != ST_IDLE)
      begin
        tmo_q <= tmo_q + 32'h0000_0001;
      end
      case (state_q)
        ST_ADDR, ST_WR:
        begin
          if (scl_rise && (bit_q != 4'h8))
          begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end
          else if (scl_fall && (bit_q == 4'h8))
          begin
            bit_q <= 4'h0;
            if (state_q == ST_ADDR)
            begin
              if ((sh_q == `DMR_I2C_WR_BYTE) || (sh_q == `DMR_I2C_RD_BYTE))
              begin
                drive_q <= 1'b1;
                rd_q <= sh_q[0];
                lo_q <= 1'b0;
                idx_q <= 2'h0;
                state_q <= ST_ACK;
              end
              else
              begin
                state_q <= ST_IDLE;
              end
            end
            else
            begin
              drive_q <= 1'b1;
              state_q <= ST_ACK;
              case (idx_q)
                2'h0:
                begin
                  ptr_q[15:8] <= sh_q;
                  idx_q <= 2'h1;
                end
                2'h1:
                begin
                  ptr_q[7:0] <= sh_q;
                  idx_q <= 2'h2;
                end
                2'h2:
                begin
                  hi_q <= sh_q;
                  idx_q <= 2'h3;
                end
                default:
                begin
                  wr_go_q <= 1'b1;
                  wr_addr_q <= ptr_q;
                  wr_data_q <= {hi_q, sh_q};
                  ptr_q <= ptr_q + 16'h0001;
                  idx_q <= 2'h2;
                end
              endcase
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall && !rd_q)
          begin
            drive_q <= 1'b0;
            state_q <= ST_WR;
          end
        end
        ST_RD:
        begin
          if (scl_fall)
          begin
            if (bit_q == 4'h7)
            begin
              drive_q <= 1'b0;
              bit_q <= 4'h0;
              mack_q <= 1'b0;
              state_q <= ST_MACK;
            end
            else
            begin
              sh_q <= {sh_q[6:0], 1'b0};
              drive_q <= ~sh_q[6];
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            if (sda_s)
            begin
              state_q <= ST_IDLE;
            end
            else
            begin
              mack_q <= 1'b1;
            end
          end
        end
        default:
        begin
          drive_q <= 1'b0;
        end
      endcase
      if (load_rd)
      begin
        sh_q <= rd_byte;
        drive_q <= ~rd_byte[7];
        bit_q <= 4'h0;
        state_q <= ST_RD;
        lo_q <= ~lo_q;
        if (lo_q)
        begin
          ptr_q <= ptr_q + 16'h0001;
        end
      end
    end
  end
end

// register store, bus block, store requests
always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
  begin
    mode_q <= `DMR_RST_MODE;
    pat_q[0] <= `DMR_RST_PAT;
    pat_q[1] <= `DMR_RST_PAT;
    low_q[0] <= `DMR_RST_LOW;
    low_q[1] <= `DMR_RST_LOW;
    lvl_q[0] <= `DMR_RST_LVL;
    lvl_q[1] <= `DMR_RST_LVL;
    sw_q[0] <= `DMR_RST_SW;
    sw_q[1] <= `DMR_RST_SW;
    ofs_q[0] <= `DMR_RST_OFS;
    ofs_q[1] <= `DMR_RST_OFS;
    block_q <= 1'b0;
    frames_q <= 2'h0;
    marg_q <= 32'h0000_0000;
    nvm_wr <= 1'b0;
    nvm_addr <= 16'h0000;
    nvm_data <= 16'h0000;
  end
  else
  begin
    nvm_wr <= wr_go_q & w_opt[0];
    if (wr_go_q && w_opt[0])
    begin
      nvm_addr <= wr_addr_q;
      nvm_data <= wr_data_q;
    end
    if (mode_wr)
    begin
      mode_q <= w_code;
    end
    if (w_ram && (w_set == (`DMR_ADDR_PAT60 & `DMR_SET_MASK)))
    begin
      pat_q[w_idx] <= wr_data_q[`DMR_PAT_HI:0];
    end
    if (w_ram && (w_set == (`DMR_ADDR_LOW60 & `DMR_SET_MASK)))
    begin
      low_q[w_idx] <= wr_data_q[`DMR_LOW_HI:0];
    end
    if (w_ram && (w_set == (`DMR_ADDR_LVL60 & `DMR_SET_MASK)))
    begin
      lvl_q[w_idx] <= wr_data_q[`DMR_LVL_HI:`DMR_LVL_LO];
      sw_q[w_idx] <= wr_data_q[`DMR_LVL_SW_BIT];
    end
    if (w_ram && (w_set == (`DMR_ADDR_OFS60 & `DMR_SET_MASK)))
    begin
      ofs_q[w_idx] <= wr_data_q[`DMR_OFS_HI:0];
    end
    // silence: two vsync edges then a margin; a new mode write restarts it
    if (mode_wr)
    begin
      block_q <= 1'b1;
      frames_q <= 2'h0;
      marg_q <= 32'h0000_0000;
    end
    else if (block_q)
    begin
      if (frames_q != `DMR_BLOCK_FRAMES)
      begin
        if (vs_rise)
        begin
          frames_q <= frames_q + 2'h1;
        end
      end
      else if (marg_q >= MARGIN_CYC)
      begin
        block_q <= 1'b0;
      end
      else
      begin
        marg_q <= marg_q + 32'h0000_0001;
      end
    end
  end
end

// applied settings other than drive_mode follow the detected standard
always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
  begin
    drive_mode <= `DMR_RST_MODE;
    sixty_hz_standard <= 1'b1;
    test_pattern_select <= `DMR_RST_PAT;
    power_lower_gain <= `DMR_RST_LOW;
    constant_level_gain <= `DMR_RST_LVL;
    constant_level_switch <= `DMR_RST_SW;
    power_limit_offset <= `DMR_RST_OFS;
  end
  else
  begin
    drive_mode <= mode_q;
    sixty_hz_standard <= sixty;
    // patterns pass only with the internal clock selected
    test_pattern_select <= internal_clock_select ? pat_q[~sixty] : `DMR_RST_PAT;
    power_lower_gain <= low_q[~sixty];
    constant_level_gain <= lvl_q[~sixty];
    constant_level_switch <= sw_q[~sixty];
    power_limit_offset <= ofs_q[~sixty];
  end
end

endmodule // dmr_top

//--- dmr_map.vh
`ifndef DMR_MAP_VH
`define DMR_MAP_VH

// clock rate
`define DMR_CLK_KHZ 125000

// bus addresses of the device, write and read
`define DMR_I2C_WR_BYTE 8'hcc
`define DMR_I2C_RD_BYTE 8'hcd

// sub-addresses, full 16 bits with option bits
`define DMR_ADDR_MODE 16'h806f
`define DMR_ADDR_PAT60 16'h8114
`define DMR_ADDR_OFS60 16'h89c0
`define DMR_ADDR_LVL60 16'h89c6
`define DMR_ADDR_LOW60 16'h89da
`define DMR_ADDR_PAT50 16'ha114
`define DMR_ADDR_OFS50 16'ha9c0
`define DMR_ADDR_LVL50 16'ha9c6
`define DMR_ADDR_LOW50 16'ha9da

// option bits sit in 15:14, offset below; bit 13 picks the 50 hz set
`define DMR_OPT_HI 15
`define DMR_OPT_LO 14
`define DMR_OFS_MASK 16'h3fff
`define DMR_SET_MASK 16'h1fff
`define DMR_SET_BIT 13

// drive mode register fields and codes
`define DMR_MODE_FLAG_BIT 8
`define DMR_MODE_CODE_HI 4
`define DMR_CODE_NORMAL 5'h11
`define DMR_CODE_STEREO 5'h03
`define DMR_CODE_CINEMA 5'h05
`define DMR_CODE_DYN 5'h07

// field positions
`define DMR_PAT_HI 5
`define DMR_LOW_HI 7
`define DMR_LVL_HI 15
`define DMR_LVL_LO 8
`define DMR_LVL_SW_BIT 0
`define DMR_OFS_HI 8

// reset values
`define DMR_RST_MODE 5'h11
`define DMR_RST_PAT 6'h00
`define DMR_RST_LOW 8'h80
`define DMR_RST_LVL 8'h80
`define DMR_RST_SW 1'b0
`define DMR_RST_OFS 9'h000

// timing
`define DMR_TIMEOUT_MS 1000
`define DMR_TIMEOUT_CYC (`DMR_TIMEOUT_MS * `DMR_CLK_KHZ)
`define DMR_BLOCK_FRAMES 2'h2
`define DMR_MARGIN_US 1000
`define DMR_MARGIN_CYC (`DMR_MARGIN_US * `DMR_CLK_KHZ / 1000)
`define DMR_SPLIT_HZ 55
`define DMR_SPLIT_CYC (`DMR_CLK_KHZ * 1000 / `DMR_SPLIT_HZ)

`endif

//--- dmr_sync2.v
`timescale 1ns/100ps
module dmr_sync2 #(
  parameter W = 1,
  // reset level per bit, matches the idle level of each pin
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // levels
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

reg [W-1:0] meta_q;

always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
  begin
    meta_q <= INIT;
    sync_out <= INIT;
  end
  else
  begin
    meta_q <= async_in;
    sync_out <= meta_q;
  end
end

endmodule // dmr_sync2

//--- dmr_vsync_rate.v
`timescale 1ns/100ps
`include "dmr_map.vh"
module dmr_vsync_rate #(
  parameter [31:0] SPLIT_CYC = `DMR_SPLIT_CYC
) (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // synchronised vertical sync level
  input wire vsync_s,
  // results
  output wire vsync_rise,
  output reg sixty_hz
);

reg vs_p_q;
reg [31:0] per_q;

assign vsync_rise = vsync_s & ~vs_p_q;

always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
  begin
    vs_p_q <= 1'b0;
    per_q <= 32'h0000_0000;
    sixty_hz <= 1'b1;
  end
  else
  begin
    vs_p_q <= vsync_s;
    if (vsync_rise)
    begin
      // short period means the faster standard
      sixty_hz <= (per_q < SPLIT_CYC);
      per_q <= 32'h0000_0000;
    end
    else if (per_q != 32'hffff_ffff)
    begin
      per_q <= per_q + 32'h0000_0001;
    end
  end
end

endmodule // dmr_vsync_rate

//--- dmr_chk_sva.sv
`timescale 1ns/100ps
module dmr_chk (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // bus and system pins
  input wire scl_in,
  input wire sda_oe_n,
  input wire sys_ready,
  input wire internal_clock_select,
  input wire control_ready,
  // applied settings and store port
  input wire [4:0] drive_mode,
  input wire [5:0] test_pattern_select,
  input wire nvm_wr,
  input wire [15:0] nvm_addr
);
  logic [8:0] quiet_q;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence s_ready_up;
    ##[1:5] control_ready;
  endsequence
  // counts down from 400 after a mode change, bus must stay released while it is between 1 and 365
  always @(posedge mclk or negedge rstn)
    if (!rstn)
      quiet_q <= 9'h000;
    else if ($changed(drive_mode))
      quiet_q <= 9'h190;
    else if (quiet_q != 9'h000)
      quiet_q <= quiet_q - 9'h001;
  chk_ready_rise: assert property ($rose(sys_ready) |-> s_ready_up)
    else $error("ready output late");
  chk_quiet_unready: assert property (!control_ready |-> sda_oe_n)
    else $error("data line pulled while not ready");
  chk_pattern_gate:
    assert property (!$past(internal_clock_select) |-> test_pattern_select == 6'h00)
    else $error("pattern applied without clock select");
  chk_mode_legal:
    assert property (drive_mode inside {5'h11, 5'h03, 5'h05, 5'h07})
    else $error("illegal mode applied");
  chk_nvm_pulse: assert property (nvm_wr |=> !nvm_wr)
    else $error("store pulse too long");
  chk_nvm_option: assert property (nvm_wr |-> nvm_addr[14])
    else $error("store write without option bit");
  chk_ack_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved while clock high");
  chk_mode_quiet:
    assert property (quiet_q > 9'h000 && quiet_q < 9'h16e |-> sda_oe_n)
    else $error("bus answered right after mode change");
endmodule // dmr_chk

//--- dmr_host_model.sv
`timescale 1ns/100ps
module dmr_host_model (
  // bus pins, open drain
  output reg scl,
  output reg sda_oe_n,
  input wire sda
);
  localparam realtime Q = 31.25;
  initial
  begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  // clock low: set data, then high, sample in the middle of the high phase
  task bit_io(input logic b, output logic r);
    begin
      #Q sda_oe_n = b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q scl = 1'b0;
    end
  endtask
  task start;
    begin
      sda_oe_n = 1'b0;
      #(2 * Q) scl = 1'b0;
    end
  endtask
  task stop;
    begin
      #Q sda_oe_n = 1'b0;
      #Q scl = 1'b1;
      #Q sda_oe_n = 1'b1;
      #(4 * Q);
    end
  endtask
  task wbyte(input logic [7:0] b, output logic ack);
    integer i;
    logic r;
    begin
      for (i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
    end
  endtask
  task rbyte(input logic last, output logic [7:0] b);
    integer i;
    logic r;
    begin
      for (i = 7; i >= 0; i--)
      begin
        bit_io(1'b1, r);
        b[i] = r;
      end
      bit_io(last, r);
    end
  endtask
endmodule // dmr_host_model

//--- tb_top.sv
`timescale 1ns/100ps
`include "dmr_map.vh"
module tb_top;
  localparam MAX_CYC = 60000;
  reg mclk = 1'b0;
  reg rstn = 1'b0;
  reg sys_ready = 1'b0;
  reg ics = 1'b0;
  reg vsync = 1'b0;
  wire scl, m_oe_n, sda_out, sda_oe_n, control_ready, sixty, sw, nvm_wr;
  wire [4:0] mode;
  wire [5:0] pat;
  wire [7:0] low, lvl;
  wire [8:0] ofs;
  wire [15:0] nvm_addr, nvm_data;
  wire sda = (sda_oe_n | sda_out) & m_oe_n;
  integer n_errors = 0, n_compared = 0, cyc = 0, vper = 500, vcnt = 0, nvm_cnt = 0, i;
  logic ok, k;
  logic [15:0] d;
  logic [15:0] ra [8] = '{`DMR_ADDR_PAT60, `DMR_ADDR_OFS60, `DMR_ADDR_LVL60,
    `DMR_ADDR_LOW60, `DMR_ADDR_PAT50, `DMR_ADDR_OFS50, `DMR_ADDR_LVL50, `DMR_ADDR_LOW50};
  logic [15:0] wv [8] = '{16'h000b, 16'hffff, 16'h5501, 16'h0000,
    16'h000d, 16'hfe10, 16'haa00, 16'h00ff};
  logic [15:0] ev [8] = '{16'h000b, 16'h01ff, 16'h5501, 16'h0000,
    16'h000d, 16'h0010, 16'haa00, 16'h00ff};
  logic [4:0] codes [4] = '{5'h03, 5'h05, 5'h07, 5'h11};
  dmr_host_model m (.scl(scl), .sda_oe_n(m_oe_n), .sda(sda));
  dmr_top #(.TIMEOUT_CYC(32'h0000_07d0), .MARGIN_CYC(32'h0000_0032),
    .SPLIT_CYC(32'h0000_03e8)) DUT (
    .mclk(mclk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .vsync_in(vsync), .sys_ready(sys_ready),
    .internal_clock_select(ics), .control_ready(control_ready), .drive_mode(mode),
    .sixty_hz_standard(sixty), .test_pattern_select(pat), .power_lower_gain(low),
    .constant_level_gain(lvl), .constant_level_switch(sw), .power_limit_offset(ofs),
    .nvm_wr(nvm_wr), .nvm_addr(nvm_addr), .nvm_data(nvm_data));
  always #4 mclk = ~mclk;
  always @(negedge mclk)
  begin
    vcnt = (vcnt + 1) % vper;
    vsync = (vcnt < 10);
  end
  always @(posedge mclk)
  begin
    nvm_cnt = nvm_cnt + (nvm_wr === 1'b1);
    cyc++;
    if (cyc == MAX_CYC)
    begin
      n_errors++;
      finish_test;
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
      n_compared++;
      if (seen !== exp)
      begin
        n_errors++;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] v, input logic dat, output logic o);
    begin
      m.start;
      m.wbyte(`DMR_I2C_WR_BYTE, o);
      m.wbyte(a[15:8], k);
      o &= k;
      m.wbyte(a[7:0], k);
      o &= k;
      if (dat)
      begin
        m.wbyte(v[15:8], k);
        o &= k;
        m.wbyte(v[7:0], k);
        o &= k;
      end
      m.stop;
    end
  endtask
  task rd(input logic [15:0] a, output logic [15:0] v);
    begin
      wr(a, 16'h0000, 1'b0, ok);
      m.start;
      m.wbyte(`DMR_I2C_RD_BYTE, k);
      m.rbyte(1'b0, v[15:8]);
      m.rbyte(1'b1, v[7:0]);
      m.stop;
    end
  endtask
  // word write to the 60 hz lower gain with a stall before the data
  task tmo(input integer pause, input logic [7:0] v, input logic exp);
    begin
      m.start;
      m.wbyte(`DMR_I2C_WR_BYTE, k);
      m.wbyte(8'h89, k);
      m.wbyte(8'hda, k);
      repeat (pause) @(negedge mclk);
      m.wbyte(8'h00, k);
      m.wbyte(v, k);
      m.stop;
      chk(k, exp);
    end
  endtask
  task finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    @(negedge mclk) rstn = 1'b1;
    wr(`DMR_ADDR_LOW60, 16'h0012, 1'b1, ok);
    chk(ok, 1'b0);
    @(negedge mclk) sys_ready = 1'b1;
    for (i = 0; i < 20 && control_ready !== 1'b1; i++) @(negedge mclk);
    chk(control_ready, 1'b1);
    chk({mode, sixty, pat}, {5'h11, 1'b1, 6'h00});
    chk({low, lvl}, 16'h8080);
    chk({sw, ofs}, 10'h000);
    m.start;
    m.wbyte(8'hce, k);
    m.stop;
    chk(k, 1'b0);
    for (i = 0; i < 8; i++)
    begin
      wr(ra[i], wv[i], 1'b1, ok);
      chk(ok, 1'b1);
    end
    for (i = 0; i < 8; i++)
    begin
      rd(ra[i], d);
      chk(d, ev[i]);
    end
    chk({pat, low}, 14'h0000);
    chk({lvl, sw}, {8'h55, 1'b1});
    chk(ofs, 9'h1ff);
    @(negedge mclk) ics = 1'b1;
    repeat (2) @(negedge mclk);
    chk(pat, 6'h0b);
    vper = 2000;
    for (i = 0; i < 6000 && sixty !== 1'b0; i++) @(negedge mclk);
    repeat (2) @(negedge mclk);
    chk({pat, low}, {6'h0d, 8'hff});
    chk({lvl, sw}, {8'haa, 1'b0});
    chk(ofs, 9'h010);
    rd(`DMR_ADDR_MODE, d);
    chk(d, 16'h0011);
    vper = 500;
    for (i = 0; i < 6000 && sixty !== 1'b1; i++) @(negedge mclk);
    for (i = 0; i < 4; i++)
    begin
      wr(`DMR_ADDR_MODE, {7'h7f, 1'b0, 3'h7, codes[i]}, 1'b1, ok);
      chk({ok, mode}, {1'b1, codes[i]});
      wr(`DMR_ADDR_LOW60, 16'h0099, 1'b1, ok);
      chk(ok, 1'b0);
      repeat (2 * vper + 114) @(negedge mclk);
      rd(`DMR_ADDR_MODE, d);
      chk(d, {7'h00, 1'b1, 3'h0, codes[i]});
    end
    wr(`DMR_ADDR_MODE, 16'h001f, 1'b1, ok);
    chk({ok, mode}, {1'b1, 5'h11});
    chk(nvm_cnt[15:0], 16'h0000);
    wr(16'hc9da, 16'h0042, 1'b1, ok);
    chk(ok, 1'b1);
    chk({nvm_cnt[7:0], low}, 16'h0142);
    chk(nvm_addr, 16'hc9da);
    wr(16'h49da, 16'h0077, 1'b1, ok);
    chk({nvm_cnt[7:0], low}, 16'h0242);
    chk(nvm_data, 16'h0077);
    tmo(1000, 8'h33, 1'b1);
    chk(low, 8'h33);
    tmo(2100, 8'h44, 1'b0);
    chk(low, 8'h33);
    wr(`DMR_ADDR_PAT60, 16'h0000, 1'b1, ok);
    wr(`DMR_ADDR_PAT50, 16'h0000, 1'b1, ok);
    finish_test;
  end
endmodule // tb_top
bind dmr_top dmr_chk u_chk (
  .mclk(mclk), .rstn(rstn), .scl_in(scl_in), .sda_oe_n(sda_oe_n), .sys_ready(sys_ready),
  .internal_clock_select(internal_clock_select), .control_ready(control_ready),
  .drive_mode(drive_mode), .test_pattern_select(test_pattern_select),
  .nvm_wr(nvm_wr), .nvm_addr(nvm_addr));
